// ==== rtl/msi_aer_params.svh ====
// Contract
// - Offset F0h bits 7:0 read 05h
// - Offset F0h bits 15:8 read 00h
// - Bit 16 selects message or pin interrupts
// - Requested count bits 19:17 read 000
// - Granted count bits 22:20, reset 000
// - Upper address F8h; bit 23 flag resets 1
// - Address F4h bits 31:2, low bits zero
// - Data FCh bits 15:0, upper bits zero
// - Offset 100h bits 15:0 read 0001h
// - Offset 100h bits 19:16 read 1h
// - Offset 100h bits 31:20 read 150h
// - Error flags at 104h, fixed bit positions
// - Sticky mask bits at 108h, same positions
`ifndef MSI_AER_PARAMS_SVH
`define MSI_AER_PARAMS_SVH
// Byte offsets
`define OFS_MSI_CTL 12'h0f0
`define OFS_MSI_ADDR 12'h0f4
`define OFS_MSI_UADDR 12'h0f8
`define OFS_MSI_DATA 12'h0fc
`define OFS_AER_HDR 12'h100
`define OFS_UE_STATUS 12'h104
`define OFS_UE_MASK 12'h108
// Constant fields
`define MSI_CAP_ID 8'h05
`define MSI_NEXT_PTR 8'h00
`define MSI_REQ_COUNT 3'h0
`define MME_RST 3'h0
`define MME_MAX 3'h5
`define CAP64_RST 1'b1
`define AER_CAP_ID 16'h0001
`define AER_VERSION 4'h1
`define AER_NEXT 12'h150
// Implemented error bits: 0, 4, 20:12
`define UE_IMPL 32'h001f_f011
// Field positions in the control word
`define MSI_EN_BIT 16
`define MMC_LSB 17
`define MME_LSB 20
`define CAP64_BIT 23
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ==== rtl/msi_aer_pkg.sv ====
package msi_aer_pkg;
   // Whole register-bank state
   typedef struct packed {
      logic aw_full;
      logic [11:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic msi_en;
      logic [2:0] mme;
      logic cap64;
      logic [29:0] addr_lo;
      logic [31:0] addr_hi;
      logic [15:0] mdata;
      logic [31:0] ue_status;
      logic [31:0] ue_mask;
      logic irq;
      logic intx_n;
      logic err_report;
      logic msg_valid;
      logic [63:0] msg_addr;
      logic [31:0] msg_data;
   } state_t;
endpackage : msi_aer_pkg

// ==== rtl/msi_aer_regs.sv ====
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "msi_aer_params.svh"

module msi_aer_regs
   import msi_aer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_on_rst_n,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [31:0] err_event,
   input wire logic [4:0] msi_vector,
   output logic irq,
   output logic intx_n,
   output logic err_report,
   output logic msg_valid,
   output logic [63:0] msg_addr,
   output logic [31:0] msg_data
);

   // Registered and next state
   state_t s_q;
   state_t s_d;
   // Write commits this cycle
   logic wr_go;
   // Byte-lane mask of the held write
   logic [31:0] bm;
   // Held write data
   logic [31:0] wd;
   // Implemented error events
   logic [31:0] ev;
   // Write-one-clear vector
   logic [31:0] clr;
   // Read mux result
   logic [31:0] rd;
   // Read decode hit
   logic rd_hit;
   // Low data bits the vector may replace
   logic [15:0] lm;

   // Expand byte strobes to a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lanes

   // Read mux, reserved bits read zero
   always_comb begin
      rd = 32'h0000_0000;
      rd_hit = 1'b1;
      if (araddr == `OFS_MSI_CTL) begin
         rd[7:0] = `MSI_CAP_ID;
         rd[15:8] = `MSI_NEXT_PTR;
         rd[`MSI_EN_BIT] = s_q.msi_en;
         rd[`MMC_LSB +: 3] = `MSI_REQ_COUNT;
         rd[`MME_LSB +: 3] = s_q.mme;
         rd[`CAP64_BIT] = s_q.cap64;
      end else if (araddr == `OFS_MSI_ADDR) begin
         rd = {s_q.addr_lo, 2'b00};
      end else if (araddr == `OFS_MSI_UADDR) begin
         rd = s_q.addr_hi;
      end else if (araddr == `OFS_MSI_DATA) begin
         rd = {16'h0000, s_q.mdata};
      end else if (araddr == `OFS_AER_HDR) begin
         rd = {`AER_NEXT, `AER_VERSION, `AER_CAP_ID};
      end else if (araddr == `OFS_UE_STATUS) begin
         rd = s_q.ue_status & `UE_IMPL;
      end else if (araddr == `OFS_UE_MASK) begin
         rd = s_q.ue_mask & `UE_IMPL;
      end else begin
         // Unmapped answers with decode error
         rd_hit = 1'b0;
      end
   end

   // Next-state logic for the whole bank
   always_comb begin
      s_d = s_q;
      wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
      bm = lanes(s_q.w_strb);
      wd = s_q.w_data;
      ev = err_event & `UE_IMPL;
      clr = 32'h0000_0000;
      lm = 16'((17'h00001 << s_q.mme) - 17'h00001);

      // Address and data may arrive in either order
      if (awvalid && s_q.awready) begin
         s_d.aw_full = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (wvalid && s_q.wready) begin
         s_d.w_full = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      // Response leaves on its handshake
      if (bready && s_q.bvalid) begin
         s_d.bvalid = 1'b0;
      end

      // Commit once both halves are held
      if (wr_go) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         if (s_q.aw_addr == `OFS_MSI_CTL) begin
            if (bm[`MSI_EN_BIT]) begin
               s_d.msi_en = wd[`MSI_EN_BIT];
            end
            // reserved codes leave the field alone
            if (bm[`MME_LSB] && wd[`MME_LSB +: 3] <= `MME_MAX) begin
               s_d.mme = wd[`MME_LSB +: 3];
            end
            if (bm[`CAP64_BIT]) begin
               s_d.cap64 = wd[`CAP64_BIT];
            end
         end else if (s_q.aw_addr == `OFS_MSI_ADDR) begin
            s_d.addr_lo = (s_q.addr_lo & ~bm[31:2]) | (wd[31:2] & bm[31:2]);
         end else if (s_q.aw_addr == `OFS_MSI_UADDR) begin
            s_d.addr_hi = (s_q.addr_hi & ~bm) | (wd & bm);
         end else if (s_q.aw_addr == `OFS_MSI_DATA) begin
            s_d.mdata = (s_q.mdata & ~bm[15:0]) | (wd[15:0] & bm[15:0]);
         end else if (s_q.aw_addr == `OFS_UE_STATUS) begin
            clr = wd & bm & `UE_IMPL;
         end else if (s_q.aw_addr == `OFS_UE_MASK) begin
            s_d.ue_mask = ((s_q.ue_mask & ~bm) | (wd & bm)) & `UE_IMPL;
         end else if (s_q.aw_addr == `OFS_AER_HDR) begin
            // Read-only word, write ignored
            s_d.bresp = `RESP_OKAY;
         end else begin
            // Unmapped write
            s_d.bresp = `RESP_DECERR;
         end
      end

      // a new event wins over a clear
      s_d.ue_status = (s_q.ue_status & ~clr) | ev;
      // sticky bits clear only at power-on, ahead of the interrupt terms
      if (!power_on_rst_n) begin
         s_d.ue_status = 32'h0000_0000;
         s_d.ue_mask = 32'h0000_0000;
      end

      // Read channel, one outstanding
      if (rready && s_q.rvalid) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd;
         s_d.rresp = rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end

      // Readies stay low while a slot is busy
      s_d.awready = !s_d.aw_full && !s_d.bvalid;
      s_d.wready = !s_d.w_full && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;

      // Level interrupt from unmasked flags
      s_d.irq = |(s_d.ue_status & ~s_d.ue_mask);
      s_d.err_report = |(ev & ~s_q.ue_mask);
      // pins idle while messages are chosen
      s_d.intx_n = !(s_d.irq && !s_d.msi_en);

      s_d.msg_valid = s_d.irq && !s_q.irq && s_d.msi_en;
      if (s_d.msg_valid) begin
         // Upper half only when wide addresses are on
         s_d.msg_addr = {s_d.cap64 ? s_d.addr_hi : 32'h0000_0000, s_d.addr_lo, 2'b00};
         // Only the granted low bits carry the vector
         s_d.msg_data = {16'h0000, (s_d.mdata & ~lm) | ({11'h000, msi_vector} & lm)};
      end

      // Warm reset clears bus and message state
      if (!aresetn) begin
         s_d.aw_full = 1'b0;
         s_d.aw_addr = 12'h000;
         s_d.w_full = 1'b0;
         s_d.w_data = 32'h0000_0000;
         s_d.w_strb = 4'h0;
         s_d.awready = 1'b0;
         s_d.wready = 1'b0;
         s_d.bvalid = 1'b0;
         s_d.bresp = `RESP_OKAY;
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b0;
         s_d.rresp = `RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         s_d.msi_en = 1'b0;
         s_d.mme = `MME_RST;
         s_d.cap64 = `CAP64_RST;
         s_d.addr_lo = 30'h0000_0000;
         s_d.addr_hi = 32'h0000_0000;
         s_d.mdata = 16'h0000;
         s_d.irq = 1'b0;
         s_d.intx_n = 1'b1;
         s_d.err_report = 1'b0;
         s_d.msg_valid = 1'b0;
         s_d.msg_addr = 64'h0000_0000_0000_0000;
         s_d.msg_data = 32'h0000_0000;
      end
   end

   // Single state register, reset folded in above
   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   // Outputs straight from the state register
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rresp = s_q.rresp;
   assign rdata = s_q.rdata;
   assign irq = s_q.irq;
   assign intx_n = s_q.intx_n;
   assign err_report = s_q.err_report;
   assign msg_valid = s_q.msg_valid;
   assign msg_addr = s_q.msg_addr;
   assign msg_data = s_q.msg_data;

   // Checks run on the bus clock
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !power_on_rst_n);

   // Control word constant fields
   property p_msi_hdr;
      (arvalid && arready && araddr == `OFS_MSI_CTL) |=>
         rvalid && rdata[7:0] == `MSI_CAP_ID && rdata[15:8] == `MSI_NEXT_PTR
         && rdata[`MMC_LSB +: 3] == `MSI_REQ_COUNT && rdata[31:24] == 8'h00;
   endproperty
   a_msi_hdr: assert property (p_msi_hdr) else $error("bad control header");

   // Error capability header word
   property p_aer_hdr;
      (arvalid && arready && araddr == `OFS_AER_HDR) |=>
         rvalid && rdata == {`AER_NEXT, `AER_VERSION, `AER_CAP_ID};
   endproperty
   a_aer_hdr: assert property (p_aer_hdr) else $error("bad error header");

   // Address low bits read zero
   property p_addr_align;
      (arvalid && arready && araddr == `OFS_MSI_ADDR) |=> rdata[1:0] == 2'b00;
   endproperty
   a_addr_align: assert property (p_addr_align) else $error("address not aligned");

   // Data upper half reads zero
   property p_data_hi;
      (arvalid && arready && araddr == `OFS_MSI_DATA) |=> rdata[31:16] == 16'h0000;
   endproperty
   a_data_hi: assert property (p_data_hi) else $error("data upper half set");

   // Reserved flag bits stay clear
   property p_flag_impl;
      (s_q.ue_status & ~`UE_IMPL) == 32'h0000_0000;
   endproperty
   a_flag_impl: assert property (p_flag_impl) else $error("reserved flag set");

   // Mask writes land on the same bits
   property p_mask_wr;
      (wr_go && s_q.aw_addr == `OFS_UE_MASK && s_q.w_strb == 4'hf) |=>
         s_q.ue_mask == ($past(s_q.w_data) & `UE_IMPL);
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

   // Cleared flags go low unless hit again
   property p_w1c;
      (|clr) |=> ((s_q.ue_status & $past(clr) & ~$past(ev)) == 32'h0000_0000);
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   // An event is never lost
   property p_set_wins;
      (|ev) |=> ((s_q.ue_status & $past(ev)) == $past(ev));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   // Unmasked events reported next cycle
   property p_report;
      (|(ev & ~s_q.ue_mask)) |=> err_report;
   endproperty
   a_report: assert property (p_report) else $error("report missing");

   // Fully masked events stay silent
   property p_masked;
      ((|ev) && !(|(ev & ~s_q.ue_mask))) |=> !err_report;
   endproperty
   a_masked: assert property (p_masked) else $error("masked error reported");

   // Pins idle while messages are chosen
   property p_pin_idle;
      s_q.msi_en |-> intx_n;
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("pin used in message mode");

   // Message carries programmed address and data
   property p_msg;
      msg_valid |-> s_q.msi_en && msg_addr[31:0] == {s_q.addr_lo, 2'b00}
         && (msg_data[15:0] & ~lm) == (s_q.mdata & ~lm);
   endproperty
   a_msg: assert property (p_msg) else $error("bad message");

   // Granted count never holds a reserved code
   property p_mme;
      s_q.mme <= `MME_MAX;
   endproperty
   a_mme: assert property (p_mme) else $error("reserved count stored");

   // Interrupt level follows unmasked flags, skipping the cycle after warm reset
   property p_irq_level;
      $past(aresetn) |-> irq == (|(s_q.ue_status & ~s_q.ue_mask));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   // Message request lasts one cycle
   property p_msg_pulse;
      msg_valid |=> !msg_valid;
   endproperty
   a_msg_pulse: assert property (p_msg_pulse) else $error("message request held");

   // Pins carry the interrupt in pin mode
   property p_pin_used;
      (irq && !s_q.msi_en) |-> !intx_n;
   endproperty
   a_pin_used: assert property (p_pin_used) else $error("pin interrupt missing");

   // Write answered within two cycles
   property p_bresp;
      (awvalid && awready && wvalid && wready) |-> ##[1:2] bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write not answered");

   // Main scenarios
   c_write: cover property (bvalid && bready && bresp == `RESP_OKAY);
   // The host moves the address once taken, so match at the address handshake
   c_read: cover property (arvalid && arready && araddr == `OFS_UE_STATUS);
   c_msg: cover property (msg_valid);
   c_masked: cover property ((|ev) && !(|(ev & ~s_q.ue_mask)));

endmodule : msi_aer_regs

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
// Configuration host, acting as AXI4-Lite master of the register bank
module host_model (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus at time zero
   initial begin
      awaddr = 12'h000;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hf;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 12'h000;
      arvalid = 1'b0;
      rready = 1'b0;
   end
   // callers pass legal codes only
   // Payload inverted once taken, so stale values are never mistaken for live ones
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   // One read, data taken at the rvalid edge
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr <= ~a;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : host_model

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench for the interrupt and error capability registers
module testbench
   import msi_aer_pkg::*;
;
   logic aclk, aresetn, power_on_rst_n;
   logic [11:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, err_event, msg_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [4:0] msi_vector;
   logic irq, intx_n, err_report, msg_valid;
   logic [63:0] msg_addr;
   int miscompares = 0;
   int checks_done = 0;
   host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   msi_aer_regs uut (.aclk(aclk), .aresetn(aresetn), .power_on_rst_n(power_on_rst_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .err_event(err_event), .msi_vector(msi_vector),
      .irq(irq), .intx_n(intx_n), .err_report(err_report), .msg_valid(msg_valid),
      .msg_addr(msg_addr), .msg_data(msg_data));
   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // Compare any result
   task automatic chk(input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // Write, expecting the given response
   task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host.wr(a, d, 4'hf, r);
      chk(er, r);
   endtask : wrc
   // Write with chosen byte lanes
   task automatic wrp(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic [1:0] r;
      host.wr(a, d, s, r);
      chk(er, r);
   endtask : wrp
   // Read, expecting data and response
   task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      host.rd(a, d, r);
      chk(ed, d);
      chk(er, r);
   endtask : rdc
   // One-cycle error pulse, then settle after the sampling edge
   task automatic pulse(input logic [31:0] b);
      @(posedge aclk);
      err_event <= b;
      @(posedge aclk);
      err_event <= 32'h0;
      #1;
   endtask : pulse
   // Values after power-up
   task automatic t_reset();
      rdc(12'h0f0, 32'h0080_0005, 2'h0);
      rdc(12'h0f4, 32'h0, 2'h0);
      rdc(12'h0f8, 32'h0, 2'h0);
      rdc(12'h0fc, 32'h0, 2'h0);
      rdc(12'h100, 32'h1501_0001, 2'h0);
      rdc(12'h104, 32'h0, 2'h0);
      rdc(12'h108, 32'h0, 2'h0);
      chk(2'b01, {irq, intx_n});
   endtask : t_reset
   // Writable, reserved and unmapped places
   task automatic t_access();
      wrc(12'h0f4, 32'hffff_ffff, 2'h0);
      rdc(12'h0f4, 32'hffff_fffc, 2'h0);
      wrc(12'h0f8, 32'hffff_ffff, 2'h0);
      rdc(12'h0f8, 32'hffff_ffff, 2'h0);
      // Only lanes 0 and 2 are written, the others keep their ones
      wrp(12'h0f8, 32'h0000_0000, 4'h5, 2'h0);
      rdc(12'h0f8, 32'hff00_ff00, 2'h0);
      wrc(12'h0fc, 32'hffff_ffff, 2'h0);
      rdc(12'h0fc, 32'h0000_ffff, 2'h0);
      wrc(12'h108, 32'hffff_ffff, 2'h0);
      rdc(12'h108, 32'h001f_f011, 2'h0);
      wrc(12'h100, 32'h0, 2'h0);
      rdc(12'h100, 32'h1501_0001, 2'h0);
      wrc(12'h0f0, 32'hff51_ffff, 2'h0);
      rdc(12'h0f0, 32'h0051_0005, 2'h0);
      wrc(12'h200, 32'h1, 2'h3);
      rdc(12'h200, 32'h0, 2'h3);
      wrc(12'h0f0, 32'h0080_0000, 2'h0);
      wrc(12'h108, 32'h0, 2'h0);
   endtask : t_access
   // Error recorded, reported on the pin, cleared by a one
   task automatic t_error();
      pulse(32'h0000_1000);
      // Pin mode: pin low, no message request
      chk(4'b1010, {irq, intx_n, err_report, msg_valid});
      @(posedge aclk);
      #1;
      chk(1'b0, err_report);
      pulse(32'h0000_0002);
      rdc(12'h104, 32'h0000_1000, 2'h0);
      wrc(12'h104, 32'h0, 2'h0);
      rdc(12'h104, 32'h0000_1000, 2'h0);
      wrc(12'h104, 32'h0000_1000, 2'h0);
      rdc(12'h104, 32'h0, 2'h0);
      chk(2'b01, {irq, intx_n});
   endtask : t_error
   // Masked error is recorded but silent
   task automatic t_mask();
      wrc(12'h108, 32'h0000_0010, 2'h0);
      pulse(32'h0000_0010);
      chk(3'b010, {irq, intx_n, err_report});
      rdc(12'h104, 32'h0000_0010, 2'h0);
      wrc(12'h104, 32'h0000_0010, 2'h0);
   endtask : t_mask
   // Message write with vector in the granted low bits
   task automatic t_message();
      wrc(12'h0f4, 32'h1234_5678, 2'h0);
      wrc(12'h0f8, 32'habcd_0001, 2'h0);
      wrc(12'h0fc, 32'h0000_beef, 2'h0);
      wrc(12'h0f0, 32'h00d1_0000, 2'h0);
      msi_vector <= 5'h15;
      pulse(32'h0010_0000);
      chk(3'b111, {msg_valid, intx_n, irq});
      chk(64'habcd_0001_1234_5678, msg_addr);
      chk(32'h0000_bef5, msg_data);
      // Request is a one-cycle pulse
      @(posedge aclk);
      #1;
      chk(1'b0, msg_valid);
      wrc(12'h104, 32'h0010_0000, 2'h0);
   endtask : t_message
   // Status and mask survive a warm reset only
   task automatic t_sticky();
      wrc(12'h108, 32'h0000_0001, 2'h0);
      pulse(32'h0000_0001);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(12'h104, 32'h0000_0001, 2'h0);
      rdc(12'h108, 32'h0000_0001, 2'h0);
      rdc(12'h0f4, 32'h0, 2'h0);
      // Mode, granted count and wide flag back to reset values
      rdc(12'h0f0, 32'h0080_0005, 2'h0);
      @(posedge aclk);
      power_on_rst_n <= 1'b0;
      repeat (2) @(posedge aclk);
      power_on_rst_n <= 1'b1;
      rdc(12'h104, 32'h0, 2'h0);
      rdc(12'h108, 32'h0, 2'h0);
   endtask : t_sticky
   // Main sequence, both resets held 12 cycles
   initial begin
      aresetn = 1'b0;
      power_on_rst_n = 1'b0;
      err_event = 32'h0;
      msi_vector = 5'h00;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_rst_n <= 1'b1;
      t_reset();
      t_access();
      t_error();
      t_mask();
      t_message();
      t_sticky();
      test_done();
   end
   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      #400000;
      miscompares++;
      test_done();
   end
endmodule : testbench
